// [sim/byte_memory_model.sv]
`timescale 1ns/1ns
module byte_memory_model
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        mem_req,
    input  wire logic [15:0] mem_addr,
    output logic      [7:0]  mem_rdata,
    output logic             mem_ack
);
    logic [7:0] mem [0:65535];
    int         lat = 0;
    int         cnt;

    // Known pattern so the bench can predict every table byte
    initial
    begin
        for (int i = 0; i < 65536; i++)
            mem[i] = 8'(i) ^ 8'h5A;
    end

    // Read-only port: no path exists that could write storage
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mem_ack   <= 1'b0;
            mem_rdata <= 8'hA5;
            cnt       <= 0;
        end
        else if (mem_ack || !mem_req)
        begin
            // Data not held after the ack edge
            mem_ack   <= 1'b0;
            mem_rdata <= ~mem_rdata;
            cnt       <= 0;
        end
        else if (cnt >= lat)
        begin
            mem_ack   <= 1'b1;
            mem_rdata <= mem[mem_addr];
        end
        else
            cnt <= cnt + 1;
    end
endmodule

// [sim/string_operand_checker.sv]
`timescale 1ns/1ns
module string_operand_checker
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        mem_req,
    input wire logic [15:0] mem_addr,
    input wire logic [7:0]  mem_rdata,
    input wire logic        mem_ack,
    input wire logic        busy
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    bad_addr_err_a: assert property (psel && penable && paddr > 8'h28 |-> pslverr)
        else $error("unmapped access without error response");
    bad_addr_zero_a: assert property (psel && !penable && !pwrite && paddr > 8'h28
        |=> prdata == 32'h0)
        else $error("unmapped read returned nonzero data");
    req_in_op_a: assert property (mem_req |-> busy)
        else $error("memory request outside an operation");
    addr_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
        else $error("memory request dropped or moved before ack");
    req_drop_a: assert property ($fell(mem_req) |-> $past(mem_ack))
        else $error("memory request fell without ack");
    fetch_step_a: assert property (mem_req && mem_ack ##1 mem_req
        |-> mem_addr == $past(mem_addr) + 16'h0001)
        else $error("descriptor fetch address did not step by one");
    start_busy_a: assert property (psel && penable && pwrite && paddr == 8'h00
        && pwdata[0] && !busy |=> busy)
        else $error("start not taken while idle");
    op_ends_a: assert property ($rose(busy) |-> ##[1:300] !busy)
        else $error("operation did not finish");
endmodule

// [sim/string_operand_decoder_tb_top.sv]
`timescale 1ns/1ns
`include "string_operand_map.svh"
module string_operand_decoder_tb_top;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        mem_req;
    logic [15:0] mem_addr;
    logic [7:0]  mem_rdata;
    logic        mem_ack;
    logic        busy;
    logic [31:0] r;
    logic        e;
    logic [31:0] st;
    logic [7:0]  chars [4] = '{8'h00, 8'h5A, 8'hA5, 8'h13};
    int          fail_count = 0;
    int          comparisons = 0;

    initial pclk = 1'b0;
    always #20 pclk = ~pclk;

    string_operand_decoder dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
        .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .busy(busy));
    byte_memory_model mem_i (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
        .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_ack(mem_ack));

    task final_report;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task hang;
        fail_count++;
        $display("[ERR] %0t wait ran out", $time);
        final_report();
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Holds the request until pready is seen, then one idle edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] rd, output logic er);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        for (n = 0; n < 20 && pready !== 1'b1; n++)
            @(posedge pclk);
        if (pready !== 1'b1)
            hang();
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, r, e);
    endtask

    task run_op(input logic [31:0] ctl);
        int n;
        wr(`OFS_CTRL, ctl);
        for (n = 0; n < 200 && busy !== 1'b0; n++)
            @(posedge pclk);
        if (busy !== 1'b0)
            hang();
        apb(1'b0, `OFS_STATUS, 32'h0, st, e);
        chk({31'h0, st[`ST_DONE]}, 32'h1, "done");
    endtask

    task cd(input logic [15:0] cnt, input logic [15:0] ad);
        wr(`OFS_WORD0, {16'h0, cnt});
        wr(`OFS_WORD1, {16'h0, ad});
        run_op(32'h00000001);
        chk({31'h0, st[`ST_VACANT]}, {31'h0, cnt == 16'h0}, "vacant");
        apb(1'b0, `OFS_ADDR, 32'h0, r, e);
        chk(r, (cnt == 16'h0) ? 32'h0 : {16'h0, ad}, "addr");
        apb(1'b0, `OFS_LAST, 32'h0, r, e);
        chk(r, (cnt == 16'h0) ? 32'h0 : {16'h0, ad + cnt - 16'h0001}, "last");
    endtask

    task bad_rd;
        apb(1'b0, 8'h3C, 32'h0, r, e);
        chk({31'h0, e}, 32'h1, "slverr");
        chk(r, 32'h0, "bad read");
    endtask

    task cs(input logic [7:0] c, input logic [7:0] m, input logic inl);
        logic        x;
        begin
            x = ((c ^ 8'h5A) & m) != 8'h00;
            mem_i.mem[16'h4000] = m;
            mem_i.mem[16'h4001] = 8'h00;
            mem_i.mem[16'h4002] = 8'h00;
            mem_i.mem[16'h4003] = 8'h02;
            wr(`OFS_WORD0, inl ? 32'h00004000 : {24'h0, m});
            wr(`OFS_WORD1, 32'h00000200);
            wr(`OFS_CHAR, {24'h0, c});
            run_op({27'h0, 1'b0, inl, 2'h2, 1'b1});
            chk({31'h0, st[`ST_MEMBER]}, {31'h0, x}, "member");
        end
    endtask

    task dd(input logic pk, input logic [2:0] t, input logic w15);
        begin
            wr(`OFS_WORD0, {16'h0, w15, t, 7'h00, 5'h1F});
            wr(`OFS_WORD1, 32'h0000BEEF);
            run_op({27'h0, pk, 1'b0, 2'h1, 1'b1});
            chk({29'h0, st[`ST_TYPE_LSB +: 3]}, {29'h0, t}, "type");
            chk({31'h0, st[`ST_RSVD_TYPE]}, {31'h0, pk ^ (&t[2:1])}, "rtype");
            chk({31'h0, st[`ST_RSVD_BITS]}, {31'h0, w15}, "rbits");
            apb(1'b0, `OFS_LEN, 32'h0, r, e);
            chk(r, 32'h0000001F, "len");
            apb(1'b0, `OFS_ADDR, 32'h0, r, e);
            chk(r, 32'h0000BEEF, "daddr");
        end
    endtask

    // xf is {sign stored, negative, overflow}
    task fm(input logic pk, input logic [2:0] t, input logic [4:0] len, input logic [31:0] res,
            input logic ng, input logic [31:0] xd, input logic [2:0] xf, input logic [3:0] xn);
        begin
            wr(`OFS_WORD0, {16'h0, 1'b0, t, 7'h00, len});
            wr(`OFS_RESULT, res);
            wr(`OFS_RSIGN, {31'h0, ng});
            run_op({27'h0, pk, 1'b0, 2'h3, 1'b1});
            apb(1'b0, `OFS_DEST, 32'h0, r, e);
            chk(r, xd, "dest");
            chk({29'h0, st[`ST_SIGN_STORE], st[`ST_NEG], st[`ST_OVERFLOW]},
                {29'h0, xf}, "flags");
            if (pk)
                chk({28'h0, st[`ST_SIGN_LSB +: 4]}, {28'h0, xn}, "nibble");
        end
    endtask

    initial
    begin
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({31'h0, busy}, 32'h0, "idle");
        bad_rd();
        cd(16'h0005, 16'h1000);
        cd(16'hFFFF, 16'h0001);
        cd(16'h0000, 16'h1234);
        for (int k = 0; k < 8; k++)
            for (int j = 0; j < 4; j++)
                cs(chars[j], 8'h01 << k, 1'b0);
        cs(8'h13, 8'h03, 1'b0);
        mem_i.lat = 3;
        cs(8'hA5, 8'h80, 1'b1);
        cs(8'h5A, 8'h02, 1'b1);
        mem_i.lat = 0;
        for (int t = 0; t < 8; t++)
        begin
            dd(1'b0, 3'(t), 1'b0);
            dd(1'b1, 3'(t), 1'b0);
        end
        dd(1'b0, 3'h0, 1'b1);
        fm(1'b0, 3'h0, 5'd5, 32'h00000123, 1'b0, 32'h00000123, 3'b100, 4'h0);
        fm(1'b0, 3'h0, 5'd3, 32'h00012345, 1'b1, 32'h00000345, 3'b111, 4'h0);
        fm(1'b0, 3'h2, 5'd3, 32'h00012000, 1'b1, 32'h00000000, 3'b111, 4'h0);
        fm(1'b0, 3'h1, 5'd31, 32'h87654321, 1'b0, 32'h87654321, 3'b100, 4'h0);
        fm(1'b1, 3'h6, 5'd4, 32'h00000000, 1'b1, 32'h00000000, 3'b100, 4'hC);
        fm(1'b1, 3'h6, 5'd2, 32'h00000099, 1'b1, 32'h00000099, 3'b110, 4'hD);
        fm(1'b1, 3'h7, 5'd2, 32'h00000042, 1'b0, 32'h00000042, 3'b100, 4'hF);
        fm(1'b0, 3'h0, 5'd0, 32'h00000007, 1'b0, 32'h00000000, 3'b001, 4'h0);
        fm(1'b0, 3'h4, 5'd0, 32'h00000000, 1'b1, 32'h00000000, 3'b100, 4'h0);
        fm(1'b1, 3'h6, 5'd0, 32'h00000005, 1'b1, 32'h00000000, 3'b111, 4'hD);
        final_report();
    end
endmodule

bind string_operand_decoder string_operand_checker chk_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .busy(busy));

// [verilog/decimal_formatter.sv]
`timescale 1ns/1ns
`include "string_operand_map.svh"
module decimal_formatter
(
    input  wire logic [31:0] result_bcd,
    input  wire logic        result_neg,
    input  wire logic [4:0]  dest_len,
    input  wire logic [2:0]  dest_type,
    input  wire logic        packed_class,
    output logic      [31:0] dest_bcd,
    output logic             overflow,
    output logic             sign_neg,
    output logic             sign_store,
    output logic      [3:0]  sign_nibble
);
    logic [`RESULT_DIGITS-1:0] drop;
    logic                      magnitude_nz;

    // Digits are taken as given; no nibble range check is made
    genvar i;
    generate
        for (i = 0; i < `RESULT_DIGITS; i = i + 1)
        begin : g_digit
            logic keep;
            assign keep = (5'(i) < dest_len);
            assign dest_bcd[4*i+3:4*i] = keep ? result_bcd[4*i+3:4*i] : 4'h0; // RQ17 RQ14
            assign drop[i] = !keep && (result_bcd[4*i+3:4*i] != 4'h0); // RQ18
        end
    endgenerate

    assign magnitude_nz = (result_bcd != 32'h0000_0000);
    assign overflow = |drop; // RQ18 RQ19
    // Sign follows the true result, so a truncated negative keeps minus zero
    assign sign_neg = result_neg && magnitude_nz; // RQ16 RQ15 RQ18
    assign sign_store = (dest_len != 5'h00) || packed_class
                        || (dest_type == `TYPE_TRAIL_SEP)
                        || (dest_type == `TYPE_LEAD_SEP); // RQ19

    always_comb
    begin
        if (dest_type == `TYPE_UPACKED)
            sign_nibble = `SIGN_UNSIGNED;
        else if (sign_neg)
            sign_nibble = `SIGN_MINUS; // RQ13
        else
            sign_nibble = `SIGN_PLUS; // RQ13
    end
endmodule

// [verilog/string_operand_decoder.sv]
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ns
`include "string_operand_map.svh"
module string_operand_decoder
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             mem_req,
    output logic      [15:0] mem_addr,
    input  wire logic [7:0]  mem_rdata,
    input  wire logic        mem_ack,
    output logic             busy
);
    string_operand_pkg::state_t state_reg;
    string_operand_pkg::op_t    op_reg;

    logic        inline_reg;
    logic        packed_reg;
    logic [15:0] word0_reg;
    logic [15:0] word1_reg;
    logic [15:0] char_reg;
    logic [31:0] result_reg;
    logic        rneg_reg;
    logic [15:0] desc0_reg;
    logic [15:0] desc1_reg;
    logic [1:0]  byte_cnt_reg;
    logic        mem_req_reg;
    logic [15:0] mem_addr_reg;
    logic        done_reg;
    logic        member_reg;
    logic        vacant_reg;
    logic        ovf_reg;
    logic        rsvd_type_reg;
    logic        rsvd_bits_reg;
    logic        sstore_reg;
    logic        neg_reg;
    logic [2:0]  type_reg;
    logic [3:0]  sign_reg;
    logic [15:0] len_reg;
    logic [15:0] addr_reg;
    logic [15:0] last_reg;
    logic [31:0] dest_reg;
    logic [31:0] prdata_reg;

    logic        wr_en;
    logic        rd_setup;
    logic        start;
    logic [31:0] fmt_bcd;
    logic        fmt_ovf;
    logic        fmt_neg;
    logic        fmt_sstore;
    logic [3:0]  fmt_sign;

    function automatic logic addr_mapped(input logic [7:0] a);
        case (a)
            `OFS_CTRL, `OFS_STATUS, `OFS_WORD0, `OFS_WORD1, `OFS_CHAR,
            `OFS_RESULT, `OFS_RSIGN, `OFS_LEN, `OFS_ADDR, `OFS_LAST,
            `OFS_DEST: addr_mapped = 1'b1;
            default:   addr_mapped = 1'b0;
        endcase
    endfunction

    // Reserved codes differ by class: numeric tops out at 101
    function automatic logic type_reserved(input logic pk, input logic [2:0] t);
        if (pk)
            type_reserved = (t != `TYPE_SPACKED) && (t != `TYPE_UPACKED); // RQ23
        else
            type_reserved = (t == `TYPE_SPACKED) || (t == `TYPE_UPACKED); // RQ22
    endfunction

    function automatic logic [2:0] type_field(input logic [15:0] w);
        type_field = w[`TYPE_MSB:`TYPE_LSB]; // RQ20
    endfunction

    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !addr_mapped(paddr);
    assign wr_en    = psel && penable && pwrite && addr_mapped(paddr);
    assign rd_setup = psel && !penable && !pwrite;
    assign start    = wr_en && (paddr == `OFS_CTRL) && pwdata[`CTRL_START]
                      && (state_reg == string_operand_pkg::S_IDLE);
    assign prdata   = prdata_reg;
    assign mem_req  = mem_req_reg;
    assign mem_addr = mem_addr_reg;
    assign busy     = (state_reg != string_operand_pkg::S_IDLE);

    decimal_formatter u_fmt
    (
        .result_bcd   (result_reg),
        .result_neg   (rneg_reg),
        .dest_len     (desc0_reg[`LEN_MSB:`LEN_LSB]),
        .dest_type    (type_field(desc0_reg)),
        .packed_class (packed_reg),
        .dest_bcd     (fmt_bcd),
        .overflow     (fmt_ovf),
        .sign_neg     (fmt_neg),
        .sign_store   (fmt_sstore),
        .sign_nibble  (fmt_sign)
    );

    // Software-written configuration and operands
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            op_reg     <= string_operand_pkg::OP_CHAR_DESC;
            inline_reg <= 1'b0;
            packed_reg <= 1'b0;
            word0_reg  <= `WORD_RESET;
            word1_reg  <= `WORD_RESET;
            char_reg   <= `WORD_RESET;
            result_reg <= 32'h0000_0000;
            rneg_reg   <= 1'b0;
        end
        else if (wr_en && !busy)
        begin
            case (paddr)
                `OFS_CTRL:
                begin
                    op_reg     <= string_operand_pkg::op_t'(pwdata[`CTRL_OP_LSB+1:`CTRL_OP_LSB]);
                    inline_reg <= pwdata[`CTRL_INLINE];
                    packed_reg <= pwdata[`CTRL_PACKED];
                end
                `OFS_WORD0:  word0_reg  <= pwdata[15:0];
                `OFS_WORD1:  word1_reg  <= pwdata[15:0];
                `OFS_CHAR:   char_reg   <= pwdata[15:0];
                `OFS_RESULT: result_reg <= pwdata;
                `OFS_RSIGN:  rneg_reg   <= pwdata[0];
                default:     ;
            endcase
        end
    end

    // Sequencer: optional in-line fetch, then execute, then table lookup for OP_CHARSET only
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg    <= string_operand_pkg::S_IDLE;
            byte_cnt_reg <= 2'h0;
            mem_req_reg  <= 1'b0;
            mem_addr_reg <= 16'h0000;
        end
        else
        begin
            case (state_reg)
                string_operand_pkg::S_IDLE:
                begin
                    if (start && pwdata[`CTRL_INLINE])
                    begin
                        // WORD0 holds the pointer word from the instruction stream
                        state_reg    <= string_operand_pkg::S_FETCH; // RQ5
                        byte_cnt_reg <= 2'h0;
                        mem_req_reg  <= 1'b1;
                        mem_addr_reg <= word0_reg;
                    end
                    else if (start)
                        state_reg <= string_operand_pkg::S_EXEC; // RQ5
                end
                string_operand_pkg::S_FETCH:
                begin
                    if (mem_ack)
                    begin
                        byte_cnt_reg <= byte_cnt_reg + 2'h1;
                        mem_addr_reg <= mem_addr_reg + 16'h0001;
                        if (byte_cnt_reg == 2'h3)
                        begin
                            mem_req_reg <= 1'b0;
                            state_reg   <= string_operand_pkg::S_EXEC;
                        end
                    end
                end
                string_operand_pkg::S_EXEC:
                begin
                    if (op_reg == string_operand_pkg::OP_CHARSET)
                    begin
                        // Character value indexes from entry zero of the table
                        state_reg    <= string_operand_pkg::S_LOOKUP;
                        mem_req_reg  <= 1'b1;
                        mem_addr_reg <= desc1_reg + {8'h00, char_reg[7:0]}; // RQ6 RQ1
                    end
                    else
                        state_reg <= string_operand_pkg::S_DONE;
                end
                string_operand_pkg::S_LOOKUP:
                begin
                    if (mem_ack)
                    begin
                        mem_req_reg <= 1'b0;
                        state_reg   <= string_operand_pkg::S_DONE;
                    end
                end
                string_operand_pkg::S_DONE:
                    state_reg <= string_operand_pkg::S_IDLE; // RQ24
                default:
                    state_reg <= string_operand_pkg::S_IDLE; // RQ24
            endcase
        end
    end

    // Effective descriptor words, from registers or from memory bytes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            desc0_reg <= `WORD_RESET;
            desc1_reg <= `WORD_RESET;
        end
        else if (start && !pwdata[`CTRL_INLINE])
        begin
            desc0_reg <= word0_reg; // RQ5
            desc1_reg <= word1_reg;
        end
        else if (state_reg == string_operand_pkg::S_FETCH && mem_ack)
        begin
            // Words are low byte first
            case (byte_cnt_reg)
                2'h0:    desc0_reg[7:0]  <= mem_rdata;
                2'h1:    desc0_reg[15:8] <= mem_rdata;
                2'h2:    desc1_reg[7:0]  <= mem_rdata;
                default: desc1_reg[15:8] <= mem_rdata;
            endcase
        end
    end

    // Completion flag: cleared by a new start, set when the op finishes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            done_reg <= 1'b0;
        else if (state_reg == string_operand_pkg::S_DONE)
            done_reg <= 1'b1;
        else if (start)
            done_reg <= 1'b0;
    end

    // Membership; high byte of the mask word is ignored rather than faulted
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            member_reg <= 1'b0;
        else if (state_reg == string_operand_pkg::S_LOOKUP && mem_ack)
            member_reg <= (mem_rdata & desc0_reg[7:0]) != 8'h00; // RQ7 RQ8 RQ9
    end

    // Character string view, else decimal length and address fields
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            len_reg    <= 16'h0000;
            addr_reg   <= 16'h0000;
            last_reg   <= 16'h0000;
            vacant_reg <= 1'b0;
        end
        else if (state_reg == string_operand_pkg::S_EXEC
                 && op_reg == string_operand_pkg::OP_CHAR_DESC)
        begin
            len_reg    <= desc0_reg; // RQ3
            vacant_reg <= (desc0_reg == 16'h0000); // RQ4
            // First byte is the most significant character, last the least
            addr_reg   <= (desc0_reg == 16'h0000) ? 16'h0000 : desc1_reg; // RQ2 RQ4
            last_reg   <= (desc0_reg == 16'h0000) ? 16'h0000
                          : desc1_reg + desc0_reg - 16'h0001; // RQ2
        end
        else if (state_reg == string_operand_pkg::S_EXEC)
        begin
            len_reg    <= {11'h000, desc0_reg[`LEN_MSB:`LEN_LSB]}; // RQ20 RQ11
            addr_reg   <= desc1_reg; // RQ20
            last_reg   <= 16'h0000;
            vacant_reg <= (desc0_reg[`LEN_MSB:`LEN_LSB] == 5'h00);
        end
    end

    // Decimal descriptor decode and result formatting
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            type_reg      <= 3'h0;
            rsvd_type_reg <= 1'b0;
            rsvd_bits_reg <= 1'b0;
            ovf_reg       <= 1'b0;
            sstore_reg    <= 1'b0;
            neg_reg       <= 1'b0;
            sign_reg      <= 4'h0;
            dest_reg      <= 32'h0000_0000;
        end
        else if (state_reg == string_operand_pkg::S_EXEC
                 && (op_reg == string_operand_pkg::OP_DEC_DESC
                     || op_reg == string_operand_pkg::OP_FORMAT))
        begin
            type_reg      <= type_field(desc0_reg); // RQ20 RQ10
            // Reported only; the op still completes normally
            rsvd_type_reg <= type_reserved(packed_reg, type_field(desc0_reg)); // RQ21 RQ24
            rsvd_bits_reg <= desc0_reg[15] || (desc0_reg[11:5] != 7'h00); // RQ21
            if (op_reg == string_operand_pkg::OP_FORMAT)
            begin
                ovf_reg    <= fmt_ovf; // RQ18 RQ19
                sstore_reg <= fmt_sstore; // RQ19
                neg_reg    <= fmt_neg; // RQ16
                sign_reg   <= fmt_sign; // RQ13
                dest_reg   <= fmt_bcd; // RQ17 RQ12
            end
        end
    end

    // Read data is latched in the setup phase and stands through access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_reg <= 32'h0000_0000;
        else if (rd_setup)
        begin
            case (paddr)
                `OFS_CTRL:   prdata_reg <= {27'h0, packed_reg, inline_reg, op_reg, 1'b0};
                `OFS_STATUS: prdata_reg <= {12'h000, sign_reg, 1'b0, type_reg,
                                            3'h0, neg_reg, sstore_reg, rsvd_bits_reg,
                                            rsvd_type_reg, ovf_reg, vacant_reg,
                                            member_reg, done_reg, busy};
                `OFS_WORD0:  prdata_reg <= {16'h0000, word0_reg};
                `OFS_WORD1:  prdata_reg <= {16'h0000, word1_reg};
                `OFS_CHAR:   prdata_reg <= {16'h0000, char_reg};
                `OFS_RESULT: prdata_reg <= result_reg;
                `OFS_RSIGN:  prdata_reg <= {31'h0, rneg_reg};
                `OFS_LEN:    prdata_reg <= {16'h0000, len_reg};
                `OFS_ADDR:   prdata_reg <= {16'h0000, addr_reg};
                `OFS_LAST:   prdata_reg <= {16'h0000, last_reg};
                `OFS_DEST:   prdata_reg <= dest_reg;
                default:     prdata_reg <= 32'h0000_0000;
            endcase
        end
    end
endmodule

// [verilog/string_operand_map.svh]
`ifndef STRING_OPERAND_MAP_SVH
`define STRING_OPERAND_MAP_SVH
// Contract
// RQ1: A single character sits in the low byte; high byte must be zero.
// RQ2: A character string is addressed by its lowest byte, most significant first.
// RQ3: Character descriptor holds a 16-bit count (0..65,535) and lowest address.
// RQ4: Zero count means vacant and the address is ignored; nonzero is occupied.
// RQ5: Descriptors come from two registers or two memory words via a pointer.
// RQ6: Character-set descriptor gives a 256-byte table base and an 8-bit mask.
// RQ7: Member when table byte at base plus character ANDed with mask is nonzero.
// RQ8: Each mask bit picks one subset; the set is the union of picked subsets.
// RQ9: Software keeps the high byte of the first character-set word zero.
// RQ10: Numeric class has six types, packed class two; operands mix freely.
// RQ11: Decimal strings hold 0 to 31 digits, integer valued, signed or absolute.
// RQ12: Digits are four-bit binary coded nibbles 0000 through 1001.
// RQ13: Destinations use the preferred encoding; sources accept alternates.
// RQ14: Decimal sources are not checked; bad encodings give any result.
// RQ15: Zero magnitude source means the same whatever its sign.
// RQ16: A zero magnitude result is treated and stored as positive.
// RQ17: Surplus most significant destination digits are filled with zeros.
// RQ18: Too short destination drops high digits, flags overflow, may hold minus zero.
// RQ19: Zero-length destination stores no digits; sign only for separate and packed.
// RQ20: Word0 bits 4..0 digit count, bits 14..12 type; word1 is the address.
// RQ21: Unused descriptor bits and reserved types must be zero by software.
// RQ22: Numeric types 000..101 zoned, overpunch, separate; 110 and 111 reserved.
// RQ23: Packed types 110 signed and 111 unsigned; 000 through 101 reserved.
// RQ24: Unpredictable cases still finish deterministically and never write memory.

`define OFS_CTRL       8'h00
`define OFS_STATUS     8'h04
`define OFS_WORD0      8'h08
`define OFS_WORD1      8'h0C
`define OFS_CHAR       8'h10
`define OFS_RESULT     8'h14
`define OFS_RSIGN      8'h18
`define OFS_LEN        8'h1C
`define OFS_ADDR       8'h20
`define OFS_LAST       8'h24
`define OFS_DEST       8'h28

`define CTRL_START     0
`define CTRL_OP_LSB    1
`define CTRL_INLINE    3
`define CTRL_PACKED    4

`define ST_BUSY        0
`define ST_DONE        1
`define ST_MEMBER      2
`define ST_VACANT      3
`define ST_OVERFLOW    4
`define ST_RSVD_TYPE   5
`define ST_RSVD_BITS   6
`define ST_SIGN_STORE  7
`define ST_NEG         8
`define ST_TYPE_LSB    12
`define ST_SIGN_LSB    16

`define LEN_LSB        0
`define LEN_MSB        4
`define TYPE_LSB       12
`define TYPE_MSB       14

`define TYPE_TRAIL_SEP 3'h4
`define TYPE_LEAD_SEP  3'h5
`define TYPE_SPACKED   3'h6
`define TYPE_UPACKED   3'h7

`define SIGN_PLUS      4'hC
`define SIGN_MINUS     4'hD
`define SIGN_UNSIGNED  4'hF

`define RESULT_DIGITS  8
`define WORD_RESET     16'h0000
`endif

// [verilog/string_operand_pkg.sv]
package string_operand_pkg;
    typedef enum logic [1:0] {
        OP_CHAR_DESC,
        OP_DEC_DESC,
        OP_CHARSET,
        OP_FORMAT
    } op_t;

    typedef enum logic [2:0] {
        S_IDLE,
        S_FETCH,
        S_EXEC,
        S_LOOKUP,
        S_DONE
    } state_t;
endpackage
